// File: orpp_output_regs.sv
// Output register bank with preload path and power-up reset
`timescale 1ns/10ps
// Contract
// - Preload forces each output register high or low, bypassing product-term logic.
// - Preload stores the pin level directly, independent of output polarity selection.
// - With preload selected, a clock pulse high loads all ten registers at once.
// - Power-up event clears every register low, needing no clock edge.
// - After power-up reset each output shows cleared value through its polarity.
module orpp_output_regs
    import orpp_pkg::*;
#(
    parameter int NREG = orpp_pkg::NUM_REGS
) (
    input  wire logic            clock,                  // System clock, 100 MHz
    input  wire logic            sys_rst,                // Power-up event, async, active high
    input  wire logic            regClkPin,              // Register clock pin from outside
    input  wire logic            preloadSelect,          // Preload condition from outside
    input  wire logic [NREG-1:0] ioPinIn,                // I/O pin levels from outside
    input  wire logic [NREG-1:0] logicNext,              // Product-term next values
    input  wire logic [NREG-1:0] output_polarity_select, // 1 inverts the output
    output logic      [NREG-1:0] ioPinOut,               // Output level to the pins
    output logic      [NREG-1:0] ioPinOe_n,              // Low while driving the pins
    output logic      [NREG-1:0] regState,               // Register contents
    output logic                 porBusy                 // High during reset interval
);
    import orpp_pkg::*;

    // ==========================================================
    // Input synchronisers
    // The first stages are read only by the second stages
    logic [NREG+1:0] syncA_reg;
    logic [NREG+1:0] syncB_reg;
    logic            clkPinDly_reg;
    logic            clkRise;
    logic            pinSelect;
    logic [NREG-1:0] pinData;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            syncA_reg <= '0;
            syncB_reg <= '0;
        end else begin
            syncA_reg <= {ioPinIn, preloadSelect, regClkPin};
            syncB_reg <= syncA_reg;
        end
    end

    assign pinData   = syncB_reg[NREG+1:2];
    assign pinSelect = syncB_reg[1];

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            clkPinDly_reg <= 1'b0;
        end else begin
            clkPinDly_reg <= syncB_reg[0];
        end
    end

    assign clkRise = syncB_reg[0] & ~clkPinDly_reg;

    // ==========================================================
    // Power-up reset interval
    // Clock edges are ignored until the interval ends, so a pin clock
    // that moves too early cannot corrupt the cleared state
    logic [POR_CNT_W-1:0] porCnt_reg;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            porCnt_reg <= POR_CNT_W'(POR_INTERVAL_CYCLES);
        end else if (porCnt_reg != '0) begin
            porCnt_reg <= porCnt_reg - POR_CNT_W'(1);
        end
    end

    assign porBusy = (porCnt_reg != '0);

    // ==========================================================
    // Register bank
    logic [NREG-1:0] bank_reg;
    logic [NREG-1:0] bank_next;

    always_comb begin
        bank_next = bank_reg;
        if (clkRise && !porBusy) begin
            if (pinSelect) begin
                bank_next = pinData;
            end else begin
                bank_next = logicNext;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bank_reg <= REG_RESET[NREG-1:0];
        end else begin
            bank_reg <= bank_next;
        end
    end

    assign regState = bank_reg;

    // ==========================================================
    // Output buffers
    // Pins are released during preload so the outside party can drive them
    logic [NREG-1:0] pinOut_reg;
    logic [NREG-1:0] pinOe_n_reg;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pinOut_reg  <= '0;
            pinOe_n_reg <= '1;
        end else begin
            pinOut_reg  <= bank_next ^ output_polarity_select;
            pinOe_n_reg <= {NREG{pinSelect}};
        end
    end

    assign ioPinOut  = pinOut_reg;
    assign ioPinOe_n = pinOe_n_reg;
endmodule

// File: orpp_pkg.sv
// Package for the output register bank with preload and power-up reset
package orpp_pkg;
    // ==========================================================
    // Sizes
    localparam int NUM_REGS = 10;

    // ==========================================================
    // Reset values
    localparam logic [NUM_REGS-1:0] REG_RESET = 10'h000;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS        = 10;
    localparam int POR_INTERVAL_TYP_NS  = 600;
    localparam int POR_INTERVAL_MAX_NS  = 1000;
    // Longest time rounds down, at least one cycle
    localparam int POR_INTERVAL_CYCLES  =
        (POR_INTERVAL_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : (POR_INTERVAL_MAX_NS / CLK_PERIOD_NS);
    localparam int POR_CNT_W            = $clog2(POR_INTERVAL_CYCLES + 1);

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [NUM_REGS-1:0] data;   // Synchronised I/O pin levels
        logic                select; // Synchronised preload select
        logic                clkPin; // Synchronised register clock pin
    } orpp_pins_t;
endpackage

// File: orpp_fixture.sv
// Board model that drives the pins of the register bank
`timescale 1ns/10ps
module orpp_fixture import orpp_pkg::*; (
    input  wire logic                clock,         // Clock
    output logic                     regClkPin,     // Clock pin
    output logic                     preloadSelect, // Preload condition
    output logic      [NUM_REGS-1:0] ioPinIn        // Pin levels
);
    initial {regClkPin, preloadSelect, ioPinIn} = '0;
    // Data settles before the pulse and stays past it, then flips so stale values show
    task automatic pulse(input logic s, input logic [NUM_REGS-1:0] d);
        {preloadSelect, ioPinIn} = {s, d};
        repeat (4) @(negedge clock);
        regClkPin = 1'h1;
        repeat (3) @(negedge clock);
        regClkPin = 1'h0;
        repeat (2) @(negedge clock);
        // Flip one edge before returning, so a following call never drives the pins twice at once
        ioPinIn = ~d;
        @(negedge clock);
    endtask
endmodule

// File: orpp_output_regs_chk.sv
// Port assertions for the output register bank
`timescale 1ns/10ps
module orpp_output_regs_chk import orpp_pkg::*; #(parameter int NREG = NUM_REGS) (
    input wire logic            clock,                  // Clock
    input wire logic            sys_rst,                // Power-up event
    input wire logic            regClkPin,              // Clock pin
    input wire logic            preloadSelect,          // Preload
    input wire logic [NREG-1:0] ioPinIn,                // Pin levels
    input wire logic [NREG-1:0] logicNext,              // Term values
    input wire logic [NREG-1:0] output_polarity_select, // Polarity
    input wire logic [NREG-1:0] ioPinOut,               // Output levels
    input wire logic [NREG-1:0] regState,               // Bank
    input wire logic            porBusy                 // Reset interval
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Synchroniser delays the load a few cycles, hence the ranges below
    sequence s_rise; $rose(regClkPin) && !porBusy; endsequence
    a_reset_clear: assert property (disable iff (1'b0) sys_rst |-> regState == '0)
        else $error("bank not cleared in reset");
    a_busy_hold: assert property (porBusy |-> regState == '0)
        else $error("bank loaded during reset interval");
    a_power_out: assert property ($fell(sys_rst) |=> ioPinOut == output_polarity_select)
        else $error("output after reset not polarity");
    a_out_polarity: assert property (!$past(sys_rst) |->
        ioPinOut == (regState ^ output_polarity_select)) else $error("output not bank xor polarity");
    a_preload_load: assert property (s_rise ##0 preloadSelect |-> ##[2:6] regState == ioPinIn)
        else $error("preload not taken from pins");
    a_normal_load: assert property (s_rise ##0 !preloadSelect |-> ##[2:6] regState == logicNext)
        else $error("normal load not taken from terms");
endmodule
bind orpp_output_regs orpp_output_regs_chk #(.NREG(NREG)) chk_u (.*);

// File: tb.sv
// Self-checking bench for the register bank
`timescale 1ns/10ps
module tb;
    import orpp_pkg::*;
    localparam logic [NUM_REGS-1:0] POL = 10'h2A5;
    logic                clock = 1'h0, sys_rst, regClkPin, preloadSelect, porBusy;
    logic [NUM_REGS-1:0] ioPinIn, ioPinOut, ioPinOe_n, regState, logicNext = '0;
    logic [NUM_REGS-1:0] output_polarity_select = POL;
    int                  err_count = 0, samples_checked = 0;
    initial forever #5 clock = ~clock;
    orpp_fixture fx_u (.*);
    orpp_output_regs dut_u (.*);
    task automatic chk(input logic [NUM_REGS-1:0] got, exp);
        samples_checked++;
        if (got !== exp) begin err_count++; $display("FAIL %0t %h %h", $time, got, exp); end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // A pulse inside the reset interval must leave the bank cleared
    task automatic t_power();
        sys_rst = 1'h1;
        repeat (16) @(negedge clock);
        sys_rst = 1'h0;
        @(negedge clock);
        chk(regState, '0);
        chk(ioPinOut, POL);
        fx_u.pulse(1'h1, 10'h3FF);
        chk(regState, '0);
        $display("t_power done");
    endtask
    task automatic t_preload();
        logic [NUM_REGS-1:0] d [3] = '{10'h3FF, 10'h000, 10'h15A};
        for (int i = 0; i < 200 && porBusy !== 1'h0; i++) @(negedge clock);
        foreach (d[i]) begin
            fx_u.pulse(1'h1, d[i]);
            chk(regState, d[i]);
            chk(ioPinOut, d[i] ^ POL);
            chk(ioPinOe_n, '1);
        end
        $display("t_preload done");
    endtask
    task automatic t_normal();
        logicNext = 10'h0C3;
        fx_u.pulse(1'h0, 10'h3C0);
        chk(regState, 10'h0C3);
        chk(ioPinOut, 10'h0C3 ^ POL);
        chk(ioPinOe_n, '0);
        $display("t_normal done");
    endtask
    initial #50000 begin
        err_count++;
        summarize();
    end
    initial begin
        t_power();
        t_preload();
        t_normal();
        t_power();
        summarize();
    end
endmodule
